/* dv/eia_link_chk.sv */
// Checker on the link: vectors, enable gating, ack blocking, readback.
// Assumes the bench top instantiates it beside the link interface.
`timescale 1ns/10ps
`include "eia_consts.svh"
module eia_link_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host to device
  input wire logic wr_en,
  input wire logic rd_en,
  input wire eia_pkg::eia_sel_t sel,
  input wire eia_pkg::eia_byte_t wdata,
  input wire logic ack,
  input wire eia_pkg::eia_vec_t ack_vec,
  // Device to host
  input wire eia_pkg::eia_byte_t rdata,
  input wire logic irq,
  input wire eia_pkg::eia_vec_t irq_vec
);
  logic [1:0] en_q;
  logic [1:0] ack_q;
  logic pc;
  logic ack_wr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Decodes: pin-change vector for the assertions, ack write for the ack shadow
  assign pc = irq_vec == `EIA_PIN_CHANGE_VECTOR;
  assign ack_wr = wr_en && sel == `EIA_SEL_ACK;
  // Shadow enable and ack bits; a set beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (srst) begin
      en_q <= 2'h0;
      ack_q <= 2'h0;
    end else begin
      if (wr_en && sel == `EIA_SEL_ENABLE) begin
        en_q <= wdata[1:0];
      end
      ack_q <= (ack_q & ~({2{ack_wr}} & wdata[1:0]))
        | {ack && ack_vec == `EIA_USER_LOGIC_VECTOR, ack && ack_vec == `EIA_PIN_CHANGE_VECTOR};
    end
  end
  sequence s_take;
    irq && ack && ack_vec == irq_vec;
  endsequence
  sequence s_rd_en;
    rd_en && !wr_en && sel == `EIA_SEL_ENABLE;
  endsequence
  sequence s_rd_ack;
    rd_en && !wr_en && !ack && sel == `EIA_SEL_ACK;
  endsequence
  AST_VEC_IDLE: assert property (!irq |-> irq_vec == 5'h00)
    else $error("vector not zero while idle");
  AST_VEC_LEGAL: assert property (irq |-> irq_vec == 5'h17 || irq_vec == 5'h18)
    else $error("illegal vector");
  AST_ENABLE: assert property (irq |-> (pc ? en_q[0] : en_q[1]))
    else $error("request without enable");
  AST_ACK_BLOCK: assert property (irq |-> !(pc ? ack_q[0] : ack_q[1]))
    else $error("request while acknowledged");
  AST_ACK_DROP: assert property (s_take |=> !irq || irq_vec != $past(irq_vec))
    else $error("request kept after ack");
  AST_RST: assert property (disable iff (1'b0) srst |=> !irq && rdata == 8'h00)
    else $error("outputs not clear after reset");
  AST_RD_EN: assert property (s_rd_en |=> rdata == {6'h00, en_q})
    else $error("enable readback wrong");
  AST_RD_ACK: assert property (s_rd_ack |=> rdata == {6'h00, ack_q})
    else $error("ack readback wrong");
  AST_RD_HIGH: assert property (rd_en && sel <= `EIA_SEL_ACK |=> rdata[7:2] == 6'h00)
    else $error("unused bits not zero");
endmodule

/* dv/tb.sv */
// Bench top: device and host joined by the link, user sides driven.
// Assumes package, link and design files compile ahead of this one.
`timescale 1ns/10ps
`include "eia_consts.svh"
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] pin_notify = 6'h00;
  logic [7:0] user_logic_set = 8'h00;
  logic [1:0] ext_flags_out;
  logic user_wr = 1'b0;
  logic user_rd = 1'b0;
  logic [2:0] user_sel = 3'h0;
  logic [7:0] user_wdata = 8'h00;
  logic [7:0] user_rdata;
  logic service_done = 1'b0;
  logic isr_active;
  logic [4:0] isr_vec;
  int failures = 0;
  int checked = 0;
  eia_pkg::eia_byte_t d;
  // Clock of 5 ns
  always #2.5 clk = ~clk;
  eia_if i_eia_if ();
  eia_device i_eia_device (.clk(clk), .srst(srst), .link(i_eia_if), .pin_notify(pin_notify),
    .user_logic_set(user_logic_set), .ext_flags_out(ext_flags_out));
  eia_host i_eia_host (.clk(clk), .srst(srst), .link(i_eia_if), .user_wr(user_wr),
    .user_rd(user_rd), .user_sel(user_sel), .user_wdata(user_wdata),
    .user_rdata(user_rdata), .service_done(service_done), .isr_active(isr_active),
    .isr_vec(isr_vec));
  eia_link_chk i_eia_link_chk (.clk(clk), .srst(srst), .wr_en(i_eia_if.wr_en),
    .rd_en(i_eia_if.rd_en), .sel(i_eia_if.sel), .wdata(i_eia_if.wdata),
    .ack(i_eia_if.ack), .ack_vec(i_eia_if.ack_vec), .rdata(i_eia_if.rdata),
    .irq(i_eia_if.irq), .irq_vec(i_eia_if.irq_vec));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input eia_pkg::eia_byte_t got, input eia_pkg::eia_byte_t exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input eia_pkg::eia_sel_t s, input eia_pkg::eia_byte_t v);
    @(posedge clk);
    user_wr <= 1'b1;
    user_sel <= s;
    user_wdata <= v;
    @(posedge clk);
    user_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input eia_pkg::eia_sel_t s, output eia_pkg::eia_byte_t v);
    @(posedge clk);
    user_rd <= 1'b1;
    user_sel <= s;
    @(posedge clk);
    user_rd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    v = user_rdata;
  endtask
  task automatic pulse_ul(input eia_pkg::eia_byte_t v);
    @(posedge clk);
    user_logic_set <= v;
    @(posedge clk);
    user_logic_set <= 8'h00;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic wait_isr(input eia_pkg::eia_vec_t v);
    int n;
    n = 0;
    while (isr_active !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h00, isr_active}, 8'h01);
    chk({3'h0, isr_vec}, {3'h0, v});
  endtask
  task automatic service;
    @(posedge clk);
    service_done <= 1'b1;
    @(posedge clk);
    service_done <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk({7'h00, isr_active}, 8'h00);
    rd(`EIA_SEL_ACK, d);
    chk(d, 8'h00);
    chk({6'h00, ext_flags_out}, 8'h00);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int s = 0; s < 4; s++) begin
      rd(s[2:0], d);
      chk(d, 8'h00);
    end
    $display("test reset done");
  endtask
  task automatic t_regs;
    wr(`EIA_SEL_ENABLE, 8'hFF);
    rd(`EIA_SEL_ENABLE, d);
    chk(d, 8'h03);
    wr(`EIA_SEL_ENABLE, 8'h02);
    rd(`EIA_SEL_ENABLE, d);
    chk(d, 8'h02);
    wr(`EIA_SEL_MASK, 8'hFD);
    rd(`EIA_SEL_MASK, d);
    chk(d, 8'h01);
    wr(`EIA_SEL_FLAGS, 8'hFF);
    wr(`EIA_SEL_ACK, 8'hFF);
    rd(`EIA_SEL_FLAGS, d);
    chk(d, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_user;
    wr(`EIA_SEL_ENABLE, 8'h00);
    wr(`EIA_SEL_MASK, 8'h00);
    pulse_ul(8'h20);
    chk({6'h00, ext_flags_out}, 8'h00);
    rd(`EIA_SEL_UL_FLAGS, d);
    chk(d, 8'h20);
    wr(`EIA_SEL_MASK, 8'h02);
    chk({6'h00, ext_flags_out}, 8'h02);
    chk({7'h00, isr_active}, 8'h00);
    wr(`EIA_SEL_UL_FLAGS, 8'hFF);
    chk({6'h00, ext_flags_out}, 8'h00);
    rd(`EIA_SEL_UL_FLAGS, d);
    chk(d, 8'h00);
    pulse_ul(8'h01);
    wr(`EIA_SEL_ENABLE, 8'h02);
    wait_isr(5'h18);
    repeat (2) @(posedge clk);
    #1;
    chk({6'h00, ext_flags_out}, 8'h00);
    chk({7'h00, i_eia_if.irq}, 8'h00);
    service;
    $display("test user logic done");
  endtask
  task automatic t_pin;
    wr(`EIA_SEL_PC_ENABLE, 8'h04);
    wr(`EIA_SEL_PC_MASK, 8'h04);
    rd(`EIA_SEL_PC_MASK, d);
    chk(d, 8'h04);
    rd(`EIA_SEL_ENABLE, d);
    wr(`EIA_SEL_ENABLE, d | 8'h01);
    rd(`EIA_SEL_MASK, d);
    wr(`EIA_SEL_MASK, d | 8'h01);
    @(posedge clk);
    pin_notify <= 6'h04;
    wait_isr(5'h17);
    @(posedge clk);
    pin_notify <= 6'h00;
    repeat (3) @(posedge clk);
    pin_notify <= 6'h04;
    repeat (8) @(posedge clk);
    #1;
    chk({7'h00, i_eia_if.irq}, 8'h00);
    service;
    rd(`EIA_SEL_PC_FLAGS, d);
    chk(d, 8'h00);
    $display("test pin change done");
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_regs;
    t_user;
    t_pin;
    final_report;
  end
  // Watchdog well past the expected run
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    final_report;
  end
endmodule

/* logic/eia_device.sv */
// Extended interrupt aggregator device end: first-level pin-change and
// user-logic sources merged into two core vectors.
// Assumes the host drives the link synchronously on clk; pin-change
// notifications arrive from outside the clock domain.
// The pin-change vector wins when both aggregator requests pend.
// A core acknowledge blocks its flag until software writes one to the
// ack bit; the source flag must be cleared first or the request returns.
// Reads of unused register bits give zero; writes to them are dropped.
`timescale 1ns/10ps
`include "eia_consts.svh"
module eia_device (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Link to the core
  eia_if.device link,
  // Source events
  input wire logic [`EIA_NUM_PORTS-1:0] pin_notify,
  input wire logic [`EIA_REG_WIDTH-1:0] user_logic_set,
  // Status view
  output logic [`EIA_NUM_SRC-1:0] ext_flags_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Pin synchroniser and edge memory
    logic [`EIA_NUM_PORTS-1:0] sync1;
    logic [`EIA_NUM_PORTS-1:0] sync2;
    logic [`EIA_NUM_PORTS-1:0] sync3;
    // Source and aggregator registers
    eia_pkg::eia_byte_t ul_flags;
    logic [`EIA_NUM_SRC-1:0] flags;
    logic [`EIA_NUM_SRC-1:0] enable;
    logic [`EIA_NUM_SRC-1:0] mask;
    logic [`EIA_NUM_SRC-1:0] ack;
    // Registered link outputs
    eia_pkg::eia_byte_t rdata;
    logic irq;
    eia_pkg::eia_vec_t irq_vec;
  } eia_dev_s;

  eia_dev_s st_q;
  eia_dev_s st_d;

  // ----------------------------------------------------------------
  // Local signals
  // ----------------------------------------------------------------
  // First-level collector view
  logic [`EIA_NUM_PORTS-1:0] pc_flags;
  logic [`EIA_NUM_PORTS-1:0] pc_enable;
  logic [`EIA_NUM_PORTS-1:0] pc_mask;
  logic pc_request;
  logic [`EIA_NUM_PORTS-1:0] pc_notify;
  // Per-source terms
  logic [`EIA_NUM_SRC-1:0] src_req;
  logic [`EIA_NUM_SRC-1:0] ack_in;
  logic [`EIA_NUM_SRC-1:0] pend;
  // Write strobes and read selection
  logic wr_flags_pc;
  logic wr_enable_pc;
  logic wr_mask_pc;
  logic wr_enable_agg;
  logic wr_mask_agg;
  logic wr_ack_agg;
  logic wr_flags_ul;
  eia_pkg::eia_byte_t rd_mux;

  // ----------------------------------------------------------------
  // Write decode and pin edge
  // ----------------------------------------------------------------
  // Selector match for a write strobe
  function automatic logic wr_hit(input eia_pkg::eia_sel_t s);
    wr_hit = link.wr_en && (link.sel == s);
  endfunction

  // One strobe per writable register
  assign wr_flags_pc = wr_hit(`EIA_SEL_PC_FLAGS);
  assign wr_enable_pc = wr_hit(`EIA_SEL_PC_ENABLE);
  assign wr_mask_pc = wr_hit(`EIA_SEL_PC_MASK);
  assign wr_enable_agg = wr_hit(`EIA_SEL_ENABLE);
  assign wr_mask_agg = wr_hit(`EIA_SEL_MASK);
  assign wr_ack_agg = wr_hit(`EIA_SEL_ACK);
  assign wr_flags_ul = wr_hit(`EIA_SEL_UL_FLAGS);

  // Rising edge of the second synchroniser stage; the third stage
  // holds the last level, so a pin held high gives a single event
  assign pc_notify = st_q.sync2 & ~st_q.sync3;

  // ----------------------------------------------------------------
  // First-level pin-change collector
  // ----------------------------------------------------------------
  eia_pin_change_src #(
    .NPORT(`EIA_NUM_PORTS)
  ) u_pc (
    .clk(clk),
    .srst(srst),
    .notify(pc_notify),
    .wr_flags(wr_flags_pc),
    .wr_enable(wr_enable_pc),
    .wr_mask(wr_mask_pc),
    .wdata(link.wdata[`EIA_NUM_PORTS-1:0]),
    .flags(pc_flags),
    .enable(pc_enable),
    .mask(pc_mask),
    .request(pc_request)
  );

  // ----------------------------------------------------------------
  // Source requests and acknowledge decode
  // ----------------------------------------------------------------
  // Bit 0 carries the pin-change group, bit 1 the user-logic group
  assign src_req[`EIA_BIT_PIN_CHANGE] = pc_request;
  assign src_req[`EIA_BIT_USER_LOGIC] = |st_q.ul_flags;

  // One acknowledge decode per aggregator bit, keyed by its vector
  for (genvar gi = 0; gi < `EIA_NUM_SRC; gi++) begin : g_ack
    localparam eia_pkg::eia_vec_t VEC = (gi == `EIA_BIT_PIN_CHANGE) ?
      `EIA_PIN_CHANGE_VECTOR : `EIA_USER_LOGIC_VECTOR;
    assign ack_in[gi] = link.ack && (link.ack_vec == VEC);
  end

  // ----------------------------------------------------------------
  // Aggregator next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Pin levels pass two stages before any logic reads them
    st_d.sync1 = pin_notify;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    // User-logic flags: write one clears, new events win
    if (wr_flags_ul) begin
      st_d.ul_flags = st_q.ul_flags & ~link.wdata;
    end
    st_d.ul_flags = st_d.ul_flags | user_logic_set;
    // Whole-byte writes for enable and mask
    if (wr_enable_agg) begin
      st_d.enable = link.wdata[`EIA_NUM_SRC-1:0];
    end
    if (wr_mask_agg) begin
      st_d.mask = link.wdata[`EIA_NUM_SRC-1:0];
    end
    // Acknowledge: core set wins over software clear,
    // so an acknowledge landing with a clear is never lost
    if (wr_ack_agg) begin
      st_d.ack = st_q.ack & ~link.wdata[`EIA_NUM_SRC-1:0];
    end
    st_d.ack = st_d.ack | ack_in;
    // Flags follow masked, unacknowledged source request; the next ack
    // value drops the flag on the very edge at which the ack bit sets,
    // so no second request reaches the core
    st_d.flags = src_req & st_q.mask & ~st_d.ack;
    // Request to the core; pin-change vector has priority
    // and a pending user-logic request waits behind it
    pend = st_d.flags & st_d.enable;
    st_d.irq = |pend;
    if (pend[`EIA_BIT_PIN_CHANGE]) begin
      st_d.irq_vec = `EIA_PIN_CHANGE_VECTOR;
    end else if (pend[`EIA_BIT_USER_LOGIC]) begin
      st_d.irq_vec = `EIA_USER_LOGIC_VECTOR;
    end else begin
      st_d.irq_vec = '0;
    end
    // Registered read data, zero when no read is taken
    st_d.rdata = link.rd_en ? rd_mux : `EIA_REG_RESET;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Register view picked by the selector; unused bits read as zero
  always_comb begin
    rd_mux = `EIA_REG_RESET;
    case (link.sel)
      `EIA_SEL_FLAGS: rd_mux[`EIA_NUM_SRC-1:0] = st_q.flags;
      `EIA_SEL_ENABLE: rd_mux[`EIA_NUM_SRC-1:0] = st_q.enable;
      `EIA_SEL_MASK: rd_mux[`EIA_NUM_SRC-1:0] = st_q.mask;
      `EIA_SEL_ACK: rd_mux[`EIA_NUM_SRC-1:0] = st_q.ack;
      `EIA_SEL_PC_FLAGS: rd_mux[`EIA_NUM_PORTS-1:0] = pc_flags;
      `EIA_SEL_PC_ENABLE: rd_mux[`EIA_NUM_PORTS-1:0] = pc_enable;
      `EIA_SEL_PC_MASK: rd_mux[`EIA_NUM_PORTS-1:0] = pc_mask;
      `EIA_SEL_UL_FLAGS: rd_mux = st_q.ul_flags;
      default: rd_mux = `EIA_REG_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset clears every register and output
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every link output and the status view come straight from flops
  assign link.rdata = st_q.rdata;
  assign link.irq = st_q.irq;
  assign link.irq_vec = st_q.irq_vec;
  assign ext_flags_out = st_q.flags;
endmodule

/* logic/eia_host.sv */
// Core-side end: takes an aggregated vector, acknowledges it, and after
// the user signals service done clears the source flag then the ack.
// Assumes the device registers its outputs on clk.
`timescale 1ns/10ps
`include "eia_consts.svh"
module eia_host (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Link to the device
  eia_if.host link,
  // User side: register access
  input wire logic user_wr,
  input wire logic user_rd,
  input wire logic [`EIA_SEL_WIDTH-1:0] user_sel,
  input wire logic [`EIA_REG_WIDTH-1:0] user_wdata,
  output logic [`EIA_REG_WIDTH-1:0] user_rdata,
  // User side: interrupt service
  input wire logic service_done,
  output logic isr_active,
  output logic [`EIA_VEC_WIDTH-1:0] isr_vec
);
  typedef struct packed {
    eia_pkg::eia_host_state_e state;
    logic wr_en;
    logic rd_en;
    eia_pkg::eia_sel_t sel;
    eia_pkg::eia_byte_t wdata;
    logic ack;
    eia_pkg::eia_vec_t vec;
    eia_pkg::eia_byte_t rdata;
    logic isr;
  } eia_host_s;

  eia_host_s st_q;
  eia_host_s st_d;

  // Sequencer: take vector, ack, wait, clear source then ack
  always_comb begin
    st_d = st_q;
    st_d.wr_en = 1'b0;
    st_d.rd_en = 1'b0;
    st_d.ack = 1'b0;
    st_d.rdata = link.rdata;
    case (st_q.state)
      eia_pkg::EIA_H_IDLE: begin
        if (link.irq) begin
          st_d.ack = 1'b1;
          st_d.vec = link.irq_vec;
          st_d.state = eia_pkg::EIA_H_WAIT;
        end else if (user_wr || user_rd) begin
          st_d.wr_en = user_wr;
          st_d.rd_en = user_rd && !user_wr;
          st_d.sel = user_sel;
          st_d.wdata = user_wdata;
        end
      end
      eia_pkg::EIA_H_WAIT: begin
        if (service_done) begin
          st_d.wr_en = 1'b1;
          st_d.wdata = `EIA_REG_RESET;
          if (st_q.vec == `EIA_PIN_CHANGE_VECTOR) begin
            st_d.sel = `EIA_SEL_PC_FLAGS;
            st_d.wdata[`EIA_NUM_PORTS-1:0] = '1;
          end else begin
            st_d.sel = `EIA_SEL_UL_FLAGS;
            st_d.wdata = '1;
          end
          st_d.state = eia_pkg::EIA_H_SRC;
        end
      end
      eia_pkg::EIA_H_SRC: begin
        st_d.wr_en = 1'b1;
        st_d.sel = `EIA_SEL_ACK;
        st_d.wdata = `EIA_REG_RESET;
        if (st_q.vec == `EIA_PIN_CHANGE_VECTOR) begin
          st_d.wdata[`EIA_BIT_PIN_CHANGE] = 1'b1;
        end else begin
          st_d.wdata[`EIA_BIT_USER_LOGIC] = 1'b1;
        end
        st_d.state = eia_pkg::EIA_H_ACK;
      end
      eia_pkg::EIA_H_ACK: begin
        st_d.state = eia_pkg::EIA_H_IDLE;
      end
      default: st_d.state = eia_pkg::EIA_H_IDLE;
    endcase
    // In service from the edge that takes the vector
    st_d.isr = (st_d.state != eia_pkg::EIA_H_IDLE);
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.state <= eia_pkg::EIA_H_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.wr_en = st_q.wr_en;
  assign link.rd_en = st_q.rd_en;
  assign link.sel = st_q.sel;
  assign link.wdata = st_q.wdata;
  assign link.ack = st_q.ack;
  assign link.ack_vec = st_q.vec;
  assign user_rdata = st_q.rdata;
  assign isr_active = st_q.isr;
  assign isr_vec = st_q.vec;
endmodule

/* logic/eia_pin_change_src.sv */
// First-level pin-change collector: flag, enable and mask per port group.
// Assumes notifications are already synchronised single-cycle pulses.
`timescale 1ns/10ps
`include "eia_consts.svh"
module eia_pin_change_src #(
  parameter int NPORT = `EIA_NUM_PORTS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Notifications, bit order A,E,G,J,K,PL
  input wire logic [NPORT-1:0] notify,
  // Register writes
  input wire logic wr_flags,
  input wire logic wr_enable,
  input wire logic wr_mask,
  input wire logic [NPORT-1:0] wdata,
  // State
  output logic [NPORT-1:0] flags,
  output logic [NPORT-1:0] enable,
  output logic [NPORT-1:0] mask,
  output logic request
);
  typedef struct packed {
    logic [NPORT-1:0] flags;
    logic [NPORT-1:0] enable;
    logic [NPORT-1:0] mask;
  } eia_pc_s;

  eia_pc_s st_q;
  eia_pc_s st_d;

  // Next-state: set wins over write-one-clear
  always_comb begin
    st_d = st_q;
    if (wr_flags) begin
      st_d.flags = st_q.flags & ~wdata;
    end
    st_d.flags = st_d.flags | (notify & st_q.mask);
    if (wr_enable) begin
      st_d.enable = wdata;
    end
    if (wr_mask) begin
      st_d.mask = wdata;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;
  assign enable = st_q.enable;
  assign mask = st_q.mask;
  assign request = |(st_q.flags & st_q.enable);
endmodule

/* pkg/eia_consts.svh */
// Constants of the extended interrupt aggregator: field positions, vectors,
// reset values and register selectors.
// Assumes inclusion by bare name from any file that needs these values.
//
// Behaviour
// - Bit 0 pin-change, bit 1 user logic
// - Vectors 23 pin-change, 24 user logic
// - Flag sets only when masked in, unacknowledged
// - Flag clears on acknowledge or source drop
// - Request when flag and enable both set
// - Core acknowledges taken vector; ack bit sets
// - Writing one clears ack bit; zero keeps
// - Software clears ack after servicing
// - Mask and enable writes replace whole byte
// - Reset clears every interrupt register
// - Software enables levels in fixed order
// - Re-enable: clear source flag, then ack
// - Port flag sets only when port masked
// - Port bits 0..5: A,E,G,J,K,PL
// - Writing one clears a first-level flag
`ifndef EIA_CONSTS_SVH
`define EIA_CONSTS_SVH

`define EIA_BIT_PIN_CHANGE 0
`define EIA_BIT_USER_LOGIC 1
`define EIA_NUM_SRC 2
`define EIA_REG_WIDTH 8
`define EIA_NUM_PORTS 6
`define EIA_VEC_WIDTH 5
`define EIA_PIN_CHANGE_VECTOR 5'h17
`define EIA_USER_LOGIC_VECTOR 5'h18
`define EIA_REG_RESET 8'h00
`define EIA_SEL_WIDTH 3
`define EIA_SEL_FLAGS 3'h0
`define EIA_SEL_ENABLE 3'h1
`define EIA_SEL_MASK 3'h2
`define EIA_SEL_ACK 3'h3
`define EIA_SEL_PC_FLAGS 3'h4
`define EIA_SEL_PC_ENABLE 3'h5
`define EIA_SEL_PC_MASK 3'h6
`define EIA_SEL_UL_FLAGS 3'h7

`endif

/* pkg/eia_if.sv */
// Link between the aggregator device and the core-side host.
// Assumes both ends share clk and srst.
`timescale 1ns/10ps
interface eia_if;
  logic wr_en;
  logic rd_en;
  eia_pkg::eia_sel_t sel;
  eia_pkg::eia_byte_t wdata;
  eia_pkg::eia_byte_t rdata;
  logic irq;
  eia_pkg::eia_vec_t irq_vec;
  logic ack;
  eia_pkg::eia_vec_t ack_vec;

  modport device (
    input wr_en, rd_en, sel, wdata, ack, ack_vec,
    output rdata, irq, irq_vec
  );
  modport host (
    output wr_en, rd_en, sel, wdata, ack, ack_vec,
    input rdata, irq, irq_vec
  );
endinterface

/* pkg/eia_pkg.sv */
// Types shared by the aggregator ends.
// Assumes eia_consts.svh on the include path.
`include "eia_consts.svh"
package eia_pkg;
  typedef logic [`EIA_REG_WIDTH-1:0] eia_byte_t;
  typedef logic [`EIA_VEC_WIDTH-1:0] eia_vec_t;
  typedef logic [`EIA_SEL_WIDTH-1:0] eia_sel_t;

  // Host sequencer states
  typedef enum logic [3:0] {
    EIA_H_IDLE = 4'b0001,
    EIA_H_WAIT = 4'b0010,
    EIA_H_SRC = 4'b0100,
    EIA_H_ACK = 4'b1000
  } eia_host_state_e;
endpackage
